// ==== verilog/tcs_consts.svh ====
// Register offsets, field positions, reset values and divider counts
// for the timer clock select and count block.
// Assumes an 8-bit register port with byte-wide addresses.

`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TCS_ADDR_TIMER_CONTROL 8'h88
`define TCS_ADDR_TIMER_MODE 8'h89
`define TCS_ADDR_T0_COUNT_LOW 8'h8A
`define TCS_ADDR_T1_COUNT_LOW 8'h8B
`define TCS_ADDR_T0_COUNT_HIGH 8'h8C
`define TCS_ADDR_T1_COUNT_HIGH 8'h8D
`define TCS_ADDR_CLOCK_CONTROL 8'h8E
`define TCS_ADDR_INT_STATUS 8'h90
`define TCS_ADDR_INT_MASK 8'h91

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TCS_CTL_T1_FLAG 7
`define TCS_CTL_T1_RUN 6
`define TCS_CTL_T0_FLAG 5
`define TCS_CTL_T0_RUN 4
`define TCS_MOD_T1_GATE 7
`define TCS_MOD_T1_MODE 5:4
`define TCS_MOD_T0_GATE 3
`define TCS_MOD_T0_MODE 1:0
`define TCS_CK_T1_SEL 3
`define TCS_CK_T0_SEL 2
`define TCS_CK_PRESCALE 1:0
`define TCS_CK_USED 3:0
`define TCS_INT_T0 0
`define TCS_INT_T1 1

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define TCS_BYTE_RESET 8'h00
`define TCS_CK_RESET 4'h0
`define TCS_INT_RESET 2'h0
`define TCS_EXT_RESET 3'h0
`define TCS_PRE_RESET 6'h00
`define TCS_READ_ZERO 8'h00
`define TCS_ALL_ONES 8'hFF
`define TCS_DIV_12 6'h0C
`define TCS_DIV_4 6'h04
`define TCS_DIV_48 6'h30
`define TCS_EXT_DIV_LAST 3'h7

`endif

// ==== verilog/tcs_pkg.sv ====
// Types shared by the timer clock select and count block.
// Assumes nothing of its surroundings.

package tcs_pkg;

	typedef enum logic [1:0] {
		TCS_MODE_13BIT = 2'h0,
		TCS_MODE_16BIT = 2'h1,
		TCS_MODE_RELOAD = 2'h2,
		TCS_MODE_SPLIT = 2'h3
	} tcs_mode_e;

	typedef enum logic [1:0] {
		TCS_PRE_DIV12 = 2'h0,
		TCS_PRE_DIV4 = 2'h1,
		TCS_PRE_DIV48 = 2'h2,
		TCS_PRE_EXT = 2'h3
	} tcs_prescale_e;

endpackage

// ==== verilog/tcs_count_unit.sv ====
// Next-count logic for one timer's low and high count bytes.
// Assumes the caller registers the results and gates countEn.
`timescale 1ns/100ps
`include "tcs_consts.svh"

module tcs_count_unit
	import tcs_pkg::*;
#(
	parameter int BYTE_W = 8
) (
	input wire tcs_mode_e mode,
	input wire logic countEn,
	input wire logic [BYTE_W-1:0] lo,
	input wire logic [BYTE_W-1:0] hi,
	output logic [BYTE_W-1:0] loNext,
	output logic [BYTE_W-1:0] hiNext,
	output logic overflow
);

	always_comb begin
		loNext = lo;
		hiNext = hi;
		overflow = 1'b0;
		if (countEn) begin
			unique case (mode)
				TCS_MODE_13BIT: begin
					{overflow, hiNext, loNext[4:0]} = {1'b0, hi, lo[4:0]} + 14'h0001;
				end
				TCS_MODE_16BIT: begin
					{overflow, hiNext, loNext} = {1'b0, hi, lo} + {{(2*BYTE_W){1'b0}}, 1'b1};
				end
				TCS_MODE_RELOAD: begin
					// Count from the reload byte, never altering it
					if (lo == `TCS_ALL_ONES) begin
						loNext = hi;
						overflow = 1'b1;
					end else begin
						loNext = lo + 8'h01;
					end
				end
				TCS_MODE_SPLIT: begin
					{overflow, loNext} = {1'b0, lo} + 9'h001;
				end
			endcase
		end
	end

endmodule

// ==== verilog/tcs_timer_block.sv ====
// Clock select, shared prescaler and count registers for two timers.
// Assumes a one-cycle register port and synchronous gate and ack
// inputs on clk_sys; the external clock input is synchronised here.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "tcs_consts.svh"

module tcs_timer_block
	import tcs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic timer0GateInput,
	input wire logic timer1GateInput,
	input wire logic timer0IntAck,
	input wire logic timer1IntAck,
	input wire logic extClk,
	output logic irq
);

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [7:0] timer0CountLow_reg;
	logic [7:0] timer0CountHigh_reg;
	logic [7:0] timer1CountLow_reg;
	logic [7:0] timer1CountHigh_reg;
	logic [3:0] clockControl_reg;
	logic timer0Run_reg;
	logic timer1Run_reg;
	logic timer0Flag_reg;
	logic timer1Flag_reg;
	logic timer0Gate_reg;
	logic timer1Gate_reg;
	tcs_mode_e timer0Mode_reg;
	tcs_mode_e timer1Mode_reg;
	logic [1:0] intStatus_reg;
	logic [1:0] intMask_reg;
	logic [5:0] preCount_reg;
	logic [2:0] extSync_reg;
	logic [2:0] extDiv_reg;
	logic extTick_reg;

	logic wrControl;
	logic wrMode;
	logic wrT0Low;
	logic wrT0High;
	logic wrT1Low;
	logic wrT1High;
	logic wrClock;
	logic wrStatus;
	logic wrMask;

	assign wrControl = regWrite && (regAddr == `TCS_ADDR_TIMER_CONTROL);
	assign wrMode = regWrite && (regAddr == `TCS_ADDR_TIMER_MODE);
	assign wrT0Low = regWrite && (regAddr == `TCS_ADDR_T0_COUNT_LOW);
	assign wrT0High = regWrite && (regAddr == `TCS_ADDR_T0_COUNT_HIGH);
	assign wrT1Low = regWrite && (regAddr == `TCS_ADDR_T1_COUNT_LOW);
	assign wrT1High = regWrite && (regAddr == `TCS_ADDR_T1_COUNT_HIGH);
	assign wrClock = regWrite && (regAddr == `TCS_ADDR_CLOCK_CONTROL);
	assign wrStatus = regWrite && (regAddr == `TCS_ADDR_INT_STATUS);
	assign wrMask = regWrite && (regAddr == `TCS_ADDR_INT_MASK);

	// ------------------------------------------------------------------
	// External clock: synchronise, then divide by eight
	// ------------------------------------------------------------------
	logic extRise;

	// Stage 0 feeds only stage 1; edges are seen between stages 1 and 2
	assign extRise = extSync_reg[1] && !extSync_reg[2];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			extSync_reg <= `TCS_EXT_RESET;
		end else begin
			extSync_reg <= {extSync_reg[1:0], extClk};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			extDiv_reg <= `TCS_EXT_RESET;
			extTick_reg <= 1'b0;
		end else begin
			extTick_reg <= extRise && (extDiv_reg == `TCS_EXT_DIV_LAST);
			if (extRise) begin
				extDiv_reg <= extDiv_reg + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Shared prescaler
	// ------------------------------------------------------------------
	tcs_prescale_e preSel;
	logic [5:0] preDiv;
	logic preWrap;
	logic preTick;

	assign preSel = tcs_prescale_e'(clockControl_reg[`TCS_CK_PRESCALE]);

	always_comb begin
		preDiv = `TCS_DIV_12;
		unique case (preSel)
			TCS_PRE_DIV12: preDiv = `TCS_DIV_12;
			TCS_PRE_DIV4: preDiv = `TCS_DIV_4;
			TCS_PRE_DIV48: preDiv = `TCS_DIV_48;
			TCS_PRE_EXT: preDiv = `TCS_DIV_12;
		endcase
	end

	// A shrinking divisor must not strand the count above its new end
	assign preWrap = (preCount_reg >= preDiv - 6'h01);
	assign preTick = (preSel == TCS_PRE_EXT) ? extTick_reg : preWrap;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			preCount_reg <= `TCS_PRE_RESET;
		end else if (preWrap) begin
			preCount_reg <= `TCS_PRE_RESET;
		end else begin
			preCount_reg <= preCount_reg + 6'h01;
		end
	end

	// ------------------------------------------------------------------
	// Timer clock and run selection
	// ------------------------------------------------------------------
	logic timer0Tick;
	logic timer1Tick;
	logic timer0Enable;
	logic timer1Enable;
	logic timer0HighEnable;
	logic splitMode;

	assign splitMode = (timer0Mode_reg == TCS_MODE_SPLIT);
	// Both selections draw on the same prescaler tick
	assign timer0Tick = clockControl_reg[`TCS_CK_T0_SEL] ? 1'b1 : preTick;
	assign timer1Tick = clockControl_reg[`TCS_CK_T1_SEL] ? 1'b1 : preTick;

	assign timer0Enable = timer0Tick && timer0Run_reg && (!timer0Gate_reg || timer0GateInput);
	// In split mode timer 1 runs on its mode alone, and mode 3 stops it
	always_comb begin
		if (timer1Mode_reg == TCS_MODE_SPLIT) begin
			timer1Enable = 1'b0;
		end else if (splitMode) begin
			timer1Enable = timer1Tick;
		end else begin
			timer1Enable = timer1Tick && timer1Run_reg && (!timer1Gate_reg || timer1GateInput);
		end
	end
	assign timer0HighEnable = splitMode && timer0Tick && timer1Run_reg;

	// ------------------------------------------------------------------
	// Count engines
	// ------------------------------------------------------------------
	logic [7:0] t0LowNext;
	logic [7:0] t0HighNext;
	logic [7:0] t1LowNext;
	logic [7:0] t1HighNext;
	logic t0Overflow;
	logic t1Overflow;
	logic t0HighOverflow;
	logic [7:0] t0HighSplitNext;
	logic t0FlagSet;
	logic t1FlagSet;

	tcs_count_unit #(
		.BYTE_W(8)
	) u_count0 (
		.mode(timer0Mode_reg),
		.countEn(timer0Enable),
		.lo(timer0CountLow_reg),
		.hi(timer0CountHigh_reg),
		.loNext(t0LowNext),
		.hiNext(t0HighNext),
		.overflow(t0Overflow)
	);

	tcs_count_unit #(
		.BYTE_W(8)
	) u_count1 (
		.mode(timer1Mode_reg),
		.countEn(timer1Enable),
		.lo(timer1CountLow_reg),
		.hi(timer1CountHigh_reg),
		.loNext(t1LowNext),
		.hiNext(t1HighNext),
		.overflow(t1Overflow)
	);

	assign {t0HighOverflow, t0HighSplitNext} = timer0HighEnable ?
		({1'b0, timer0CountHigh_reg} + 9'h001) : {1'b0, timer0CountHigh_reg};

	assign t0FlagSet = t0Overflow;
	// While timer 0 is split, its high byte owns the timer 1 flag
	assign t1FlagSet = splitMode ? t0HighOverflow : t1Overflow;

	// ------------------------------------------------------------------
	// Count registers: a software write wins over a count step
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer0CountLow_reg <= `TCS_BYTE_RESET;
			timer0CountHigh_reg <= `TCS_BYTE_RESET;
		end else begin
			timer0CountLow_reg <= wrT0Low ? regWdata : t0LowNext;
			if (wrT0High) begin
				timer0CountHigh_reg <= regWdata;
			end else if (splitMode) begin
				timer0CountHigh_reg <= t0HighSplitNext;
			end else begin
				timer0CountHigh_reg <= t0HighNext;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer1CountLow_reg <= `TCS_BYTE_RESET;
			timer1CountHigh_reg <= `TCS_BYTE_RESET;
		end else begin
			timer1CountLow_reg <= wrT1Low ? regWdata : t1LowNext;
			timer1CountHigh_reg <= wrT1High ? regWdata : t1HighNext;
		end
	end

	// ------------------------------------------------------------------
	// Control, mode and clock control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer0Run_reg <= 1'b0;
			timer1Run_reg <= 1'b0;
		end else if (wrControl) begin
			// Run bits only gate counting; the count is left as it stands
			timer0Run_reg <= regWdata[`TCS_CTL_T0_RUN];
			timer1Run_reg <= regWdata[`TCS_CTL_T1_RUN];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer0Flag_reg <= 1'b0;
			timer1Flag_reg <= 1'b0;
		end else begin
			// Overflow in the clearing cycle keeps the flag set
			if (t0FlagSet) begin
				timer0Flag_reg <= 1'b1;
			end else if (timer0IntAck) begin
				timer0Flag_reg <= 1'b0;
			end else if (wrControl) begin
				timer0Flag_reg <= regWdata[`TCS_CTL_T0_FLAG];
			end
			if (t1FlagSet) begin
				timer1Flag_reg <= 1'b1;
			end else if (timer1IntAck) begin
				timer1Flag_reg <= 1'b0;
			end else if (wrControl) begin
				timer1Flag_reg <= regWdata[`TCS_CTL_T1_FLAG];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer0Gate_reg <= 1'b0;
			timer1Gate_reg <= 1'b0;
			timer0Mode_reg <= TCS_MODE_13BIT;
			timer1Mode_reg <= TCS_MODE_13BIT;
		end else if (wrMode) begin
			timer0Gate_reg <= regWdata[`TCS_MOD_T0_GATE];
			timer1Gate_reg <= regWdata[`TCS_MOD_T1_GATE];
			timer0Mode_reg <= tcs_mode_e'(regWdata[`TCS_MOD_T0_MODE]);
			timer1Mode_reg <= tcs_mode_e'(regWdata[`TCS_MOD_T1_MODE]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clockControl_reg <= `TCS_CK_RESET;
		end else if (wrClock) begin
			clockControl_reg <= regWdata[`TCS_CK_USED];
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------------
	logic [1:0] intEvents;

	assign intEvents = {t1FlagSet, t0FlagSet};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			intStatus_reg <= `TCS_INT_RESET;
		end else begin
			// Write one to clear; a new event in the same cycle wins
			intStatus_reg <= (intStatus_reg & ~(wrStatus ? regWdata[1:0] : 2'h0)) | intEvents;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			intMask_reg <= `TCS_INT_RESET;
		end else if (wrMask) begin
			intMask_reg <= regWdata[1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(intStatus_reg & intMask_reg);
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdata <= `TCS_READ_ZERO;
		end else if (regRead) begin
			unique case (regAddr)
				`TCS_ADDR_TIMER_CONTROL: regRdata <= {timer1Flag_reg, timer1Run_reg,
					timer0Flag_reg, timer0Run_reg, 4'h0};
				`TCS_ADDR_TIMER_MODE: regRdata <= {timer1Gate_reg, 1'b0, timer1Mode_reg,
					timer0Gate_reg, 1'b0, timer0Mode_reg};
				`TCS_ADDR_T0_COUNT_LOW: regRdata <= timer0CountLow_reg;
				`TCS_ADDR_T0_COUNT_HIGH: regRdata <= timer0CountHigh_reg;
				`TCS_ADDR_T1_COUNT_LOW: regRdata <= timer1CountLow_reg;
				`TCS_ADDR_T1_COUNT_HIGH: regRdata <= timer1CountHigh_reg;
				`TCS_ADDR_CLOCK_CONTROL: regRdata <= {4'h0, clockControl_reg};
				`TCS_ADDR_INT_STATUS: regRdata <= {6'h00, intStatus_reg};
				`TCS_ADDR_INT_MASK: regRdata <= {6'h00, intMask_reg};
				default: regRdata <= `TCS_READ_ZERO;
			endcase
		end else begin
			regRdata <= `TCS_READ_ZERO;
		end
	end

endmodule

// ==== testbench/tcs_timer_block_properties.sv ====
// Checker for the timer block register port and interrupt output.
// Assumes it is bound to tcs_timer_block and sees only its ports.
`timescale 1ns/100ps

module tcs_timer_block_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic irq
);
	// ----------------------------------------------------------------
	// Shadows of software-owned registers
	// ----------------------------------------------------------------
	logic [3:0] ckReg;
	logic [1:0] maskReg;
	logic [1:0] modeReg;
	logic [7:0] thReg;
	logic thKnown;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ckReg <= 4'h0;
			maskReg <= 2'h0;
			modeReg <= 2'h0;
			thReg <= 8'h00;
			thKnown <= 1'b0;
		end else begin
			// High byte only trusted while it has stayed in reload mode
			thKnown <= (modeReg == 2'h2) && (thKnown || (regWrite && regAddr == 8'h8C));
			if (regWrite && regAddr == 8'h8E)
				ckReg <= regWdata[3:0];
			if (regWrite && regAddr == 8'h91)
				maskReg <= regWdata[1:0];
			if (regWrite && regAddr == 8'h89)
				modeReg <= regWdata[1:0];
			if (regWrite && regAddr == 8'h8C)
				thReg <= regWdata;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
		else $error("read data not zero outside the read slot");
	chk_clock_field: assert property (
		regRead && regAddr == 8'h8E |=> regRdata == {4'h0, $past(ckReg)})
		else $error("clock control read back wrong");
	chk_unmapped_zero: assert property (regRead && regAddr == 8'h8F |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	chk_reload_high: assert property (
		regRead && regAddr == 8'h8C && thKnown |=> regRdata == $past(thReg))
		else $error("reload value changed");
	chk_irq_masked: assert property ($past(maskReg) == 2'h0 |-> !irq)
		else $error("interrupt raised while masked");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && regRdata == 8'h00)
		else $error("outputs active after reset");
	chk_control_low: assert property (
		regRead && regAddr == 8'h88 |=> regRdata[3:0] == 4'h0)
		else $error("control low bits not zero");
	chk_mask_read: assert property (
		regRead && regAddr == 8'h91 |=> regRdata == {6'h00, $past(maskReg)})
		else $error("mask read back wrong");

	cover property (regRead && regAddr == 8'h8C && thKnown);
	cover property ($rose(irq));
	cover property (regWrite && regAddr == 8'h8E);
endmodule

bind tcs_timer_block tcs_timer_block_properties u_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.regAddr(regAddr),
	.regWdata(regWdata),
	.regWrite(regWrite),
	.regRead(regRead),
	.regRdata(regRdata),
	.irq(irq)
);

// ==== testbench/tb.sv ====
// Self-checking bench for the timer clock select and count block.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/100ps

module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdata;
	logic ack0 = 1'b0;
	logic ack1 = 1'b0;
	logic extClk = 1'b0;
	logic irq;
	int errorCnt = 0;
	int nCompared = 0;
	int cyc = 0;
	int extCnt = 0;

	tcs_timer_block u_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdata(regRdata),
		.timer0GateInput(1'b0),
		.timer1GateInput(1'b0),
		.timer0IntAck(ack0),
		.timer1IntAck(ack1),
		.extClk(extClk),
		.irq(irq)
	);

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	// External clock rises every 6 cycles, so its divided tick comes every 48
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		extCnt <= (extCnt == 2) ? 0 : extCnt + 1;
		if (extCnt == 2)
			extClk <= ~extClk;
		if (cyc == 10000) begin
			errorCnt = errorCnt + 1;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask

	task automatic chk8(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		nCompared++;
		if (regRdata !== e) begin
			errorCnt++;
			$display("CHECK FAILED %0t reg %h got %h exp %h", $time, a, regRdata, e);
		end
	endtask

	task automatic chkIrq(input logic e);
		@(posedge clk_sys);
		#1;
		nCompared++;
		if (irq !== e) begin
			errorCnt++;
			$display("CHECK FAILED %0t irq got %b exp %b", $time, irq, e);
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testReset();
		for (int i = 0; i < 10; i++)
			chk8(8'h88 + 8'(i), 8'h00);
		wr(8'h8E, 8'hFF);
		chk8(8'h8E, 8'h0F);
	endtask

	// Both timers count one 480-cycle window per clock setting
	task automatic testRates();
		logic [7:0] ck [6] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h05, 8'h01};
		int div [6] = '{12, 4, 48, 48, 4, 4};
		logic [15:0] e0;
		logic [15:0] e1;
		wr(8'h89, 8'h11);
		for (int i = 0; i < 6; i++) begin
			e0 = ck[i][2] ? 16'h01E0 : 16'(480 / div[i]);
			e1 = ck[i][3] ? 16'h01E0 : 16'(480 / div[i]);
			wr(8'h8E, ck[i]);
			wr(8'h8A, 8'h00);
			wr(8'h8C, 8'h00);
			wr(8'h8B, 8'h00);
			wr(8'h8D, 8'h00);
			wr(8'h88, 8'h50);
			repeat (478) @(posedge clk_sys);
			wr(8'h88, 8'h00);
			chk8(8'h8A, e0[7:0]);
			chk8(8'h8C, e0[15:8]);
			chk8(8'h8B, e1[7:0]);
			chk8(8'h8D, e1[15:8]);
		end
	endtask

	// Two steps from 0xFE: reload from high byte on the second
	task automatic testReload();
		wr(8'h89, 8'h02);
		wr(8'h8E, 8'h04);
		wr(8'h8C, 8'h10);
		wr(8'h8A, 8'hFE);
		wr(8'h91, 8'h01);
		wr(8'h88, 8'h10);
		wr(8'h89, 8'h0A);
		chk8(8'h8A, 8'h10);
		chk8(8'h8C, 8'h10);
		chk8(8'h88, 8'h30);
		chk8(8'h90, 8'h01);
		chkIrq(1'b1);
		@(posedge clk_sys);
		ack0 <= 1'b1;
		@(posedge clk_sys);
		ack0 <= 1'b0;
		chk8(8'h88, 8'h10);
		wr(8'h91, 8'h00);
		chkIrq(1'b0);
		wr(8'h90, 8'h01);
		chk8(8'h90, 8'h00);
		wr(8'h91, 8'h01);
		chkIrq(1'b0);
	endtask

	// High byte of timer 0 runs on timer 1 run bit and raises timer 1 flag
	task automatic testSplit();
		wr(8'h88, 8'h00);
		wr(8'h89, 8'h03);
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'h00);
		wr(8'h91, 8'h02);
		wr(8'h88, 8'h40);
		wr(8'h89, 8'h00);
		chk8(8'h8C, 8'h01);
		chk8(8'h8A, 8'h00);
		chk8(8'h88, 8'hC0);
		chk8(8'h90, 8'h02);
		chkIrq(1'b1);
		@(posedge clk_sys);
		ack1 <= 1'b1;
		@(posedge clk_sys);
		ack1 <= 1'b0;
		chk8(8'h88, 8'h40);
	endtask

	// Mode 0: two steps carry out of low bit 4 into the high byte, low bits 7:5 kept
	task automatic testMode13();
		wr(8'h8C, 8'hFF);
		wr(8'h8A, 8'hFE);
		wr(8'h88, 8'h10);
		wr(8'h89, 8'h08);
		chk8(8'h8A, 8'hE0);
		chk8(8'h8C, 8'h00);
		chk8(8'h88, 8'h30);
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		testReset();
		testRates();
		testReload();
		testSplit();
		testMode13();
		conclude();
	end
endmodule
